/* csp_serial_port.sv */
/*
 * csp_serial_port: half-duplex clock-synchronous 8-bit serial port.
 * Control and status are plain ports driven by the cpu side on REF_CLK_IN.
 * The link side runs on the level of the serial clock pin as seen at the pad,
 * which carries either our own generated clock or the far end's clock.
 */
// How it works
// [R1] software polls transmit_go low, loads, sets go
// [R2] interrupt transmit: load, set go with enable
// [R3] polled receive: set go, wait low, read
// [R4] interrupt receive: read byte, set go again
// [R5] both go bits low before changing speed
// [R6] wait one bit time before speed change
// [R7] clearing a go bit aborts that transfer
// [R8] clear go bits normally only when done
// [R9] never transmit and receive at once
// [R10] reset restores control/status reset values
// [R11] reset aborts transfer, keeps shift data
// [R12] transmit bit launched falling, held until next
// [R13] after 8 bits: clear go, set done
// [R14] interrupt when done and enable both set
// [R15] all-ones speed: clock pin is input
// [R16] shift in step with serial clock
// [R17] receive bits sampled on rising edge
`timescale 1ns/1ps
module csp_serial_port (
   input  wire logic       REF_CLK_IN,
   input  wire logic       SYS_RST_IN,
   input  wire logic       CTRL_WR_IN,
   input  wire logic       TX_GO_IN,
   input  wire logic       RX_GO_IN,
   input  wire logic       END_INT_EN_IN,
   input  wire logic [2:0] SPEED_SEL_IN,
   input  wire logic       DATA_WR_IN,
   input  wire logic       DATA_RD_IN,
   input  wire logic [7:0] DATA_IN,
   output logic      [7:0] DATA_OUT,
   output logic            TX_GO_OUT,
   output logic            RX_GO_OUT,
   output logic            END_INT_EN_OUT,
   output logic      [2:0] SPEED_SEL_OUT,
   output logic            DONE_FLAG_OUT,
   output logic            IRQ_OUT,
   input  wire logic       SERIAL_CLOCK_PIN_IN,
   output logic            SERIAL_CLOCK_PIN_OUT,
   output logic            SERIAL_CLOCK_PIN_OE_OUT,
   input  wire logic       SERIAL_IN_PIN_IN,
   output logic            SERIAL_OUT_PIN_OUT
);
   function automatic logic [11:0] half_len(input logic [2:0] sel);
      half_len = csp_pkg::HALF_BASE << sel;
   endfunction

   // cpu-side control state
   logic                     tx_go_r, tx_go_nxt;
   logic                     rx_go_r, rx_go_nxt;
   logic                     eie_r, eie_nxt;
   logic                     done_r, done_nxt;
   logic [2:0]               speed_r, speed_nxt;
   logic [7:0]               data_r, data_nxt;
   logic                     dt1_r, dt2_r, dt3_r;
   logic                     done_evt;
   logic                     lclr_r, lclr_nxt;
   // internal clock generator
   logic [csp_pkg::DIV_W-1:0] div_r, div_nxt;
   logic                      sck_r, sck_nxt;
   logic                      gen_run;
   // link-side state
   logic                     ts1_r, ts2_r, rs1_r, rs2_r;
   logic [3:0]               cnt_r, cnt_nxt;
   logic                     fin_r, fin_nxt;
   logic [7:0]               rx_sh_r, rx_sh_nxt;
   logic                     tx_out_r, tx_out_nxt;
   logic                     link_act;

   // finish level from link domain, two-flop synchroniser, rising edge only
   assign done_evt = dt2_r && !dt3_r;
   assign lclr_nxt = !(tx_go_nxt || rx_go_nxt);

   always_comb begin
      tx_go_nxt = tx_go_r;
      rx_go_nxt = rx_go_r;
      eie_nxt   = eie_r;
      done_nxt  = done_r;
      speed_nxt = speed_r;
      data_nxt  = data_r;
      // no buffer: a write mid-transfer corrupts the byte being shifted
      if (DATA_WR_IN) begin
         data_nxt = DATA_IN;
      end
      if (DATA_RD_IN || DATA_WR_IN) begin
         done_nxt = 1'b0;
      end
      if (done_evt && (tx_go_r || rx_go_r)) begin
         done_nxt  = 1'b1; // R13
         tx_go_nxt = 1'b0; // R13
         rx_go_nxt = 1'b0;
         if (rx_go_r && !DATA_WR_IN && !SYS_RST_IN) begin
            data_nxt = rx_sh_r; // R16
         end
      end
      if (CTRL_WR_IN) begin
         tx_go_nxt = TX_GO_IN; // R7
         rx_go_nxt = RX_GO_IN; // R7
         eie_nxt   = END_INT_EN_IN;
         speed_nxt = SPEED_SEL_IN;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      data_r <= data_nxt; // R11
      dt1_r  <= fin_r;
      dt2_r  <= dt1_r;
      dt3_r  <= dt2_r;
      if (SYS_RST_IN) begin
         lclr_r  <= 1'b1;            // R11
         tx_go_r <= csp_pkg::GO_RST; // R10
         rx_go_r <= csp_pkg::GO_RST; // R11
         eie_r   <= csp_pkg::EIE_RST;
         done_r  <= csp_pkg::FLAG_RST;
         speed_r <= csp_pkg::SPEED_RST;
      end else begin
         lclr_r  <= lclr_nxt;        // R7
         tx_go_r <= tx_go_nxt;
         rx_go_r <= rx_go_nxt;
         eie_r   <= eie_nxt;
         done_r  <= done_nxt;
         speed_r <= speed_nxt;
      end
   end

   // generated clock idles high so the first edge is a falling one
   assign gen_run = (speed_r != csp_pkg::SPEED_EXT) && (tx_go_r || rx_go_r);

   always_comb begin
      div_nxt = div_r;
      sck_nxt = sck_r;
      if (!gen_run) begin
         div_nxt = '0;
         sck_nxt = 1'b1;
      end else if (div_r == half_len(speed_r) - 12'h001) begin
         div_nxt = '0;
         sck_nxt = ~sck_r; // R16
      end else begin
         div_nxt = div_r + 12'h001;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         div_r <= '0;
         sck_r <= 1'b1;
      end else begin
         div_r <= div_nxt;
         sck_r <= sck_nxt;
      end
   end

   assign SERIAL_CLOCK_PIN_OE_OUT = (speed_r != csp_pkg::SPEED_EXT); // R15
   assign SERIAL_CLOCK_PIN_OUT    = sck_r;                           // R15

   // link domain: go levels cross by two flops; data bytes are quasi-static
   // because the go bits gate the shifter while they are handed over
   // limitation: the first two serial clocks after go arm the synchroniser
   assign link_act = ts2_r || rs2_r;

   always_comb begin
      cnt_nxt   = cnt_r;
      fin_nxt   = fin_r;
      rx_sh_nxt = rx_sh_r;
      if (!link_act) begin
         cnt_nxt = '0; // R7
         fin_nxt = 1'b0;
      end else if (!fin_r) begin
         if (rs2_r) begin
            rx_sh_nxt[cnt_r[2:0]] = SERIAL_IN_PIN_IN; // R17
         end
         cnt_nxt = cnt_r + 4'h1;
         if (cnt_r == csp_pkg::BIT_LAST) begin
            fin_nxt = 1'b1;    // R13
         end
      end
   end

   // go low clears the link at once: the pin clock is stopped between frames
   always_ff @(posedge SERIAL_CLOCK_PIN_IN or posedge lclr_r) begin
      if (lclr_r) begin
         ts1_r <= 1'b0; // R7
         ts2_r <= 1'b0;
         rs1_r <= 1'b0;
         rs2_r <= 1'b0;
         cnt_r <= '0;
         fin_r <= 1'b0;
      end else begin
         ts1_r <= tx_go_r;
         ts2_r <= ts1_r;
         rs1_r <= rx_go_r;
         rs2_r <= rs1_r;
         cnt_r <= cnt_nxt;
         fin_r <= fin_nxt;
      end
   end

   always_ff @(posedge SERIAL_CLOCK_PIN_IN) begin
      rx_sh_r <= rx_sh_nxt;
   end

   always_comb begin
      tx_out_nxt = tx_out_r;
      if (ts2_r && !fin_r && cnt_r < csp_pkg::BIT_COUNT) begin
         tx_out_nxt = data_r[cnt_r[2:0]]; // R12
      end
   end

   always_ff @(negedge SERIAL_CLOCK_PIN_IN) begin
      tx_out_r <= tx_out_nxt;
   end

   assign SERIAL_OUT_PIN_OUT = tx_out_r;
   assign DATA_OUT           = data_r;
   assign TX_GO_OUT          = tx_go_r;
   assign RX_GO_OUT          = rx_go_r;
   assign END_INT_EN_OUT     = eie_r;
   assign SPEED_SEL_OUT      = speed_r;
   assign DONE_FLAG_OUT      = done_r;
   assign IRQ_OUT            = done_r && eie_r; // R14

   default clocking cb @(posedge REF_CLK_IN); endclocking

   sequence hold8;
      (!gen_run || $stable(SERIAL_CLOCK_PIN_OUT)) [*8];
   endsequence

   abort_clears_a: assert property (disable iff (SYS_RST_IN) // R7
      CTRL_WR_IN && !TX_GO_IN && !RX_GO_IN |=> !TX_GO_OUT && !RX_GO_OUT)
      else $error("go bit survived a clearing write");
   reset_values_a: assert property (disable iff (1'b0) // R10
      SYS_RST_IN |=> !TX_GO_OUT && !RX_GO_OUT && !DONE_FLAG_OUT && !END_INT_EN_OUT
                     && SPEED_SEL_OUT == csp_pkg::SPEED_RST)
      else $error("control state wrong after reset");
   reset_keeps_data_a: assert property (disable iff (1'b0) // R11
      SYS_RST_IN && !DATA_WR_IN |=> DATA_OUT == $past(DATA_OUT))
      else $error("shift data changed by reset");
   done_sets_a: assert property (disable iff (SYS_RST_IN) // R13
      done_evt && (TX_GO_OUT || RX_GO_OUT) && !CTRL_WR_IN |=> DONE_FLAG_OUT && !TX_GO_OUT && !RX_GO_OUT)
      else $error("completion did not end the transfer");
   irq_gate_a: assert property (disable iff (SYS_RST_IN) // R14
      IRQ_OUT |-> DONE_FLAG_OUT && END_INT_EN_OUT)
      else $error("interrupt without flag and enable");
   clock_dir_a: assert property (disable iff (SYS_RST_IN) // R15
      SPEED_SEL_OUT == csp_pkg::SPEED_EXT |-> !SERIAL_CLOCK_PIN_OE_OUT)
      else $error("clock pin driven in external mode");
   clock_idle_a: assert property (disable iff (SYS_RST_IN) // R15
      !TX_GO_OUT && !RX_GO_OUT |=> SERIAL_CLOCK_PIN_OUT)
      else $error("generated clock not idle high");
   half_period_a: assert property (disable iff (SYS_RST_IN) // R16
      $changed(SERIAL_CLOCK_PIN_OUT) && gen_run |-> ##1 hold8)
      else $error("generated clock edge too early");
   rx_copy_a: assert property (disable iff (SYS_RST_IN) // R16
      done_evt && RX_GO_OUT && !DATA_WR_IN |=> DATA_OUT == $past(rx_sh_r))
      else $error("received byte not stored");
   tx_bit_a: assert property (@(posedge SERIAL_CLOCK_PIN_IN) disable iff (SYS_RST_IN) // R12
      ts2_r && !fin_r && cnt_r < csp_pkg::BIT_COUNT |-> SERIAL_OUT_PIN_OUT == data_r[cnt_r[2:0]])
      else $error("transmit bit not stable at rising edge");
endmodule

/* csp_pkg.sv */
/*
 * csp_pkg: constants for the clocked serial port.
 * Assumes a 250 MHz system clock; no other dependencies.
 */
package csp_pkg;
   // all-ones speed code selects the external serial clock
   localparam logic [2:0]  SPEED_EXT     = 3'h7;
   localparam logic [2:0]  SPEED_RST     = 3'h7;
   localparam logic        GO_RST        = 1'b0;
   localparam logic        EIE_RST       = 1'b0;
   localparam logic        FLAG_RST      = 1'b0;
   localparam int          DIV_W         = 12;
   // half serial period at speed code 0, in system clock cycles
   localparam logic [11:0] HALF_BASE     = 12'h014;
   localparam logic [3:0]  BIT_LAST      = 4'h7;
   localparam logic [3:0]  BIT_COUNT     = 4'h8;
endpackage

/* csp_far_end.sv */
/*
 * csp_far_end: behavioural far end of the serial link, LSB first.
 * Assumes the bench resolves the clock pin and frames it by the go bits.
 */
`timescale 1ns/1ps
module csp_far_end (
   input  wire logic       clk_pin_in,
   input  wire logic       frame_in,
   input  wire logic       ext_clk_in,
   input  wire logic [7:0] tx_byte_in,
   input  wire logic       sout_in,
   output logic            data_out,
   output logic            clk_out,
   output logic      [7:0] rx_byte_out
);
   int cnt = 0;
   // odd start offset keeps our clock unrelated to the system clock
   initial begin
      clk_out = 1'b1;
      data_out = 1'b0;
      rx_byte_out = 8'h00;
      #3.7;
      forever begin
         #6;
         clk_out = (ext_clk_in && frame_in) ? ~clk_out : 1'b1;
      end
   end
   // first two rising edges only arm the port
   always @(posedge clk_pin_in or negedge frame_in) begin
      if (!frame_in) cnt <= 0;
      else begin
         if (cnt >= 2 && cnt < 10) rx_byte_out[cnt-2] <= sout_in;
         cnt <= cnt + 1;
      end
   end
   // outside data bits the line toggles so a stale value never passes
   always @(negedge clk_pin_in) begin
      if (frame_in && cnt >= 2 && cnt < 10) data_out <= tx_byte_in[cnt-2];
      else data_out <= ~data_out;
   end
endmodule

/* csp_serial_port_tb.sv */
/*
 * csp_serial_port_tb: random transfers both ways, abort and reset cases.
 * Assumes csp_far_end as link partner; pad level resolved here.
 */
`timescale 1ns/1ps
module csp_serial_port_tb;
   logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, txg = 1'b0, rxg = 1'b0;
   logic       en = 1'b0, dwr = 1'b1, drd = 1'b0;
   logic [2:0] spd = 3'h7, spdo;
   logic [7:0] din = 8'h00, far_tx = 8'h00, dout, far_rx, b;
   logic       txo, rxo, eno, flag, irq, cko, ckoe, pin, sin, sout, fclk;
   logic [2:0] sp [3] = '{3'h0, 3'h1, 3'h7};
   int         num_errors = 0, samples_checked = 0;
   always #2 clk = ~clk;
   assign pin = ckoe ? cko : fclk;
   csp_serial_port i_csp_serial_port (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .CTRL_WR_IN(wr), .TX_GO_IN(txg),
      .RX_GO_IN(rxg), .END_INT_EN_IN(en), .SPEED_SEL_IN(spd), .DATA_WR_IN(dwr), .DATA_RD_IN(drd),
      .DATA_IN(din), .DATA_OUT(dout), .TX_GO_OUT(txo), .RX_GO_OUT(rxo), .END_INT_EN_OUT(eno),
      .SPEED_SEL_OUT(spdo), .DONE_FLAG_OUT(flag), .IRQ_OUT(irq), .SERIAL_CLOCK_PIN_IN(pin),
      .SERIAL_CLOCK_PIN_OUT(cko), .SERIAL_CLOCK_PIN_OE_OUT(ckoe), .SERIAL_IN_PIN_IN(sin),
      .SERIAL_OUT_PIN_OUT(sout));
   csp_far_end i_csp_far_end (.clk_pin_in(pin), .frame_in(txo | rxo), .ext_clk_in(~ckoe),
      .tx_byte_in(far_tx), .sout_in(sout), .data_out(sin), .clk_out(fclk), .rx_byte_out(far_rx));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic ctrl(input logic t, input logic r, input logic e, input logic [2:0] s);
      @(posedge clk);
      #1;
      wr = 1'b1;
      txg = t;
      rxg = r;
      en = e;
      spd = s;
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask
   task automatic dat(input logic w, input logic r, input logic [7:0] d);
      @(posedge clk);
      #1;
      dwr = w;
      drd = r;
      din = d;
      @(posedge clk);
      #1;
      dwr = 1'b0;
      drd = 1'b0;
   endtask
   // polls both go bits low under a bound
   task automatic wait_idle();
      int n;
      n = 0;
      while ((txo | rxo) !== 1'b0) begin
         @(posedge clk);
         n++;
         if (n > 4000) begin
            chk("wait bound", 8'h00, 8'h01);
            stop_test();
         end
      end
   endtask
   task automatic xfer(input logic t, input logic [2:0] s, input logic e);
      b = $urandom;
      far_tx = $urandom;
      dat(1'b1, 1'b0, b);
      ctrl(1'b0, 1'b0, e, s);
      ctrl(t, ~t, e, s);
      chk("clock drive", {7'h00, s != csp_pkg::SPEED_EXT}, {7'h00, ckoe});
      wait_idle();
      @(posedge clk);
      #1;
      chk("done", 8'h01, {7'h00, flag});
      chk("irq", {7'h00, e}, {7'h00, irq});
      if (t) chk("far rx", b, far_rx);
      else chk("rx data", far_tx, dout);
      dat(1'b0, 1'b1, din);
      chk("flag clr", 8'h00, {7'h00, flag});
      repeat (400) @(posedge clk);
      $display("xfer dir %0d speed %0d done", t, s);
   endtask
   initial begin
      void'($urandom(29136));
      // first reset edge loads a known shift data byte
      @(posedge clk);
      #1;
      dwr = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      chk("go bits", 8'h00, {6'h00, txo, rxo});
      chk("en flag irq", 8'h00, {5'h00, eno, flag, irq});
      chk("speed oe clk", {3'h0, csp_pkg::SPEED_RST, 2'b01}, {3'h0, spdo, ckoe, cko});
      for (int i = 0; i < 6; i++) xfer(i[0], sp[i/2], i[1]);
      // abort mid-byte: no completion may follow
      dat(1'b1, 1'b0, 8'ha5);
      ctrl(1'b1, 1'b0, 1'b1, 3'h0);
      repeat (150) @(posedge clk);
      ctrl(1'b0, 1'b0, 1'b1, 3'h0);
      repeat (1500) @(posedge clk);
      chk("abort flag", 8'h00, {6'h00, flag, txo});
      $display("abort test done");
      // reset mid-byte last: go bits clear, shift data byte is kept
      ctrl(1'b0, 1'b1, 1'b1, 3'h0);
      repeat (150) @(posedge clk);
      b = dout;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      chk("reset go", 8'h00, {6'h00, txo, rxo});
      chk("reset data", b, dout);
      chk("reset speed", {5'h00, csp_pkg::SPEED_RST}, {5'h00, spdo});
      $display("reset test done");
      stop_test();
   end
endmodule
